/* verilog/flp_pkg.sv */
//==============================================================
// shared constants of the interrupt priority controller
//==============================================================
package flp_pkg;
   // number of request sources and priority levels
   localparam int NUM_SRC = 6;
   localparam int NUM_LVL = 4;
   localparam int LVL_W = 2;
   localparam int SRC_W = 3;
   // source positions, also the fixed polling order (lowest wins)
   localparam int SRC_EXT0 = 0;
   localparam int SRC_TMR0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_TMR1 = 3;
   localparam int SRC_SER = 4;
   localparam int SRC_TMR2 = 5;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_SOURCE_ENABLE = 8'hA8;
   localparam logic [7:0] IDX_PRIORITY_HIGH = 8'hB7;
   localparam logic [7:0] IDX_PRIORITY_LOW = 8'hB8;
   localparam logic [7:0] IDX_TRIGGER_MODE = 8'hC0;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hC1;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hC2;
   localparam logic [7:0] IDX_IN_SERVICE = 8'hC3;
   // bit positions and reset values
   localparam int GLOBAL_EN_BIT = 7;
   localparam logic [7:0] SOURCE_ENABLE_RST = 8'h00;
   localparam logic [7:0] PRIORITY_RST = 8'h00;
   localparam logic [1:0] TRIGGER_MODE_RST = 2'h0;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   // status event bits
   localparam int EV_VECTORED = 0;
   localparam int EV_RETURNED = 1;
   localparam int EV_BAD_RETURN = 2;
   localparam int NUM_EV = 3;
   // vector base and spacing: 03H, 0BH, 13H ...
   localparam logic [7:0] VECTOR_BASE = 8'h03;
   localparam int VECTOR_SHIFT = 3;
endpackage : flp_pkg

/* verilog/flp_arbiter.sv */
`timescale 1ns/1ps
//==============================================================
// picks the highest level request, polling order breaks ties
//==============================================================
module flp_arbiter #(
   parameter int NUM_SRC = 6
) (
   input wire logic [NUM_SRC-1:0] pend_i,
   input wire logic [NUM_SRC-1:0] prio_high_i,
   input wire logic [NUM_SRC-1:0] prio_low_i,
   output logic found_o,
   output logic [flp_pkg::SRC_W-1:0] src_o,
   output logic [flp_pkg::LVL_W-1:0] lvl_o
);
   // the source number must fit the index width
   if (NUM_SRC < 1 || NUM_SRC > 2 ** flp_pkg::SRC_W) begin : g_bad_src
      $error("flp_arbiter: source count does not fit the index width");
   end

   // scan from the last source down so the first in order wins a tie
   always_comb begin
      found_o = 1'b0;
      src_o = '0;
      lvl_o = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         // strictly higher level replaces, equal level earlier replaces too
         if (pend_i[i] && (!found_o || {prio_high_i[i], prio_low_i[i]} >= lvl_o)) begin
            found_o = 1'b1;
            src_o = i[flp_pkg::SRC_W-1:0];
            lvl_o = {prio_high_i[i], prio_low_i[i]};
         end
      end
   end
endmodule : flp_arbiter

/* verilog/flp_nest.sv */
`timescale 1ns/1ps
//==============================================================
// nesting record: one in-service bit per priority level
//==============================================================
module flp_nest #(
   parameter int NUM_LVL = 4
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic enter_i,
   input wire logic [flp_pkg::LVL_W-1:0] enter_lvl_i,
   input wire logic leave_i,
   output logic [NUM_LVL-1:0] active_o,
   output logic busy_o,
   output logic [flp_pkg::LVL_W-1:0] top_lvl_o
);
   // every level must be reachable through the level index
   if (NUM_LVL < 1 || NUM_LVL > 2 ** flp_pkg::LVL_W) begin : g_bad_lvl
      $error("flp_nest: level count does not fit the level width");
   end

   logic [NUM_LVL-1:0] active_reg;
   logic [NUM_LVL-1:0] top_onehot; // highest active level

   // only the highest active bit is the running routine
   always_comb begin
      top_onehot = '0;
      top_lvl_o = '0;
      for (int i = 0; i < NUM_LVL; i++) begin
         if (active_reg[i]) begin
            top_onehot = '0;
            top_onehot[i] = 1'b1;
            top_lvl_o = i[flp_pkg::LVL_W-1:0];
         end
      end
   end

   // leaving drops the top level only, so a preempted routine resumes
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         active_reg <= '0;
      end else begin
         active_reg <= (active_reg & ~(leave_i ? top_onehot : '0))
            | (enter_i ? (NUM_LVL'(1) << enter_lvl_i) : '0);
      end
   end

   assign active_o = active_reg;
   assign busy_o = |active_reg;
endmodule : flp_nest

/* verilog/flp_ctrl.sv */
`timescale 1ns/1ps
//==============================================================
// How it works
// - six sources arbitrated over four levels
// - high priority register at index B7H
// - level is high bit then low bit
// - vector when nothing equal or higher runs
// - equal or lower request waits for return
// - higher level preempts running routine
// - return resumes the preempted lower routine
// - fixed polling order and vector addresses
// - clear edge externals and timers 0 and 1 only
// - low priority bit one raises level
// - low priority bits ordered, top two unused
//==============================================================
module flp_ctrl (
   input wire logic clk_i,
   input wire logic srst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // peripheral request flags
   input wire logic ext0_request_flag_i,
   input wire logic timer0_overflow_flag_i,
   input wire logic ext1_request_flag_i,
   input wire logic timer1_overflow_flag_i,
   input wire logic serial_rx_flag_i,
   input wire logic serial_tx_flag_i,
   input wire logic timer2_overflow_flag_i,
   input wire logic timer2_external_flag_i,
   // hardware clears of request flags
   output logic ext0_flag_clear_o,
   output logic timer0_flag_clear_o,
   output logic ext1_flag_clear_o,
   output logic timer1_flag_clear_o,
   // core side
   output logic vec_valid_o,
   output logic [7:0] vec_addr_o,
   input wire logic vec_ack_i,
   input wire logic reti_i,
   // summary interrupt
   output logic irq_o
);
   localparam int NS = flp_pkg::NUM_SRC;
   localparam int NL = flp_pkg::NUM_LVL;

   // the vector spacing and the level encoding only serve this shape;
   // the check runs at elaboration so a wrong package never simulates
   if (NS != 6 || NL != 4) begin : g_bad_shape
      $error("flp_ctrl supports six sources and four levels only");
   end

   //==============================================================
   // registers
   //==============================================================
   logic [7:0] source_enable_reg; // global enable in bit 7
   logic [NS-1:0] priority_high_reg;
   logic [NS-1:0] priority_low_reg;
   logic [1:0] trigger_mode_reg; // 1 = edge, ext0 bit0, ext1 bit1
   logic [flp_pkg::NUM_EV-1:0] irq_status_reg;
   logic [flp_pkg::NUM_EV-1:0] irq_mask_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic vec_valid_reg;
   logic [7:0] vec_addr_reg;
   logic [flp_pkg::SRC_W-1:0] vec_src_reg; // source being offered
   logic [flp_pkg::LVL_W-1:0] vec_lvl_reg; // its level
   logic [3:0] clear_reg; // hardware clear pulses
   logic irq_reg;

   //==============================================================
   // apb decode
   //==============================================================
   logic [7:0] idx; // register index from the word address
   logic addr_ok; // word aligned and mapped
   logic setup_ph; // setup cycle
   logic wr_en; // write takes effect this edge
   logic rd_done; // read completes this edge
   logic [31:0] rd_val; // decoded read data

   // mapped index test, used for the error answer and the read mux
   function automatic logic idx_mapped(input logic [7:0] ix);
      case (ix)
         flp_pkg::IDX_SOURCE_ENABLE,
         flp_pkg::IDX_PRIORITY_HIGH,
         flp_pkg::IDX_PRIORITY_LOW,
         flp_pkg::IDX_TRIGGER_MODE,
         flp_pkg::IDX_IRQ_STATUS,
         flp_pkg::IDX_IRQ_MASK,
         flp_pkg::IDX_IN_SERVICE: idx_mapped = 1'b1;
         default: idx_mapped = 1'b0;
      endcase
   endfunction : idx_mapped

   // upper address bits must be zero so that aliases never hit a register
   assign idx = paddr_i[9:2];
   assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0) && idx_mapped(idx);
   assign setup_ph = psel_i && !penable_i;
   // an errored write is dropped
   assign wr_en = psel_i && penable_i && pready_reg && pwrite_i && addr_ok;
   assign rd_done = psel_i && penable_i && pready_reg && !pwrite_i && addr_ok;

   //==============================================================
   // arbitration and nesting
   //==============================================================
   logic [NS-1:0] raw_req; // request per source
   logic [NS-1:0] pend; // enabled requests
   logic arb_found;
   logic [flp_pkg::SRC_W-1:0] arb_src;
   logic [flp_pkg::LVL_W-1:0] arb_lvl;
   logic [NL-1:0] active;
   logic busy;
   logic [flp_pkg::LVL_W-1:0] top_lvl;
   logic take; // core takes the offered vector
   logic leave; // core returns from a routine

   // the flags are levels owned by the peripherals; this block never holds them,
   // it only pulses a clear so that the owner drops an edge or timer flag
   // serial and timer 2 each share one request line
   assign raw_req = {timer2_overflow_flag_i | timer2_external_flag_i,
                     serial_rx_flag_i | serial_tx_flag_i,
                     timer1_overflow_flag_i, ext1_request_flag_i,
                     timer0_overflow_flag_i, ext0_request_flag_i};
   assign pend = raw_req & source_enable_reg[NS-1:0] & {NS{source_enable_reg[flp_pkg::GLOBAL_EN_BIT]}};
   // an acknowledge without a standing offer is ignored
   assign take = vec_valid_reg && vec_ack_i;
   assign leave = reti_i;

   // the arbiter is pure logic; its choice only counts in the offer process
   // six sources, four levels
   // level from high and low bits
   flp_arbiter #(
      .NUM_SRC(NS)
   ) u_arbiter (
      .pend_i(pend),
      .prio_high_i(priority_high_reg),
      .prio_low_i(priority_low_reg),
      .found_o(arb_found),
      .src_o(arb_src),
      .lvl_o(arb_lvl)
   );

   // a return with nothing in service only raises the bad return status bit
   // nesting record of levels
   flp_nest #(
      .NUM_LVL(NL)
   ) u_nest (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .enter_i(take),
      .enter_lvl_i(vec_lvl_reg),
      .leave_i(leave),
      .active_o(active),
      .busy_o(busy),
      .top_lvl_o(top_lvl)
   );

   //==============================================================
   // vector offer to the core
   //==============================================================
   // trade-off: a standing offer is never replaced by a later, higher winner,
   // so the core never sees the vector change; the higher one preempts next
   // an offer stands until taken; a newer winner waits behind it
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         vec_valid_reg <= 1'b0;
         vec_addr_reg <= 8'h00;
         vec_src_reg <= '0;
         vec_lvl_reg <= '0;
      end else if (take) begin
         vec_valid_reg <= 1'b0;
      end else if (!vec_valid_reg && !leave && arb_found && (!busy || arb_lvl > top_lvl)) begin
         vec_valid_reg <= 1'b1;
         vec_addr_reg <= flp_pkg::VECTOR_BASE + {2'h0, arb_src, 3'h0};
         vec_src_reg <= arb_src;
         vec_lvl_reg <= arb_lvl;
      end
   end

   // the clear follows the source that was offered, not the current winner,
   // since the flags may have moved by the time the core acknowledges
   // clear edge externals and timers 0 and 1
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         clear_reg <= 4'h0;
      end else begin
         clear_reg[0] <= take && vec_src_reg == 3'(flp_pkg::SRC_EXT0) && trigger_mode_reg[0];
         clear_reg[1] <= take && vec_src_reg == 3'(flp_pkg::SRC_TMR0);
         clear_reg[2] <= take && vec_src_reg == 3'(flp_pkg::SRC_EXT1) && trigger_mode_reg[1];
         clear_reg[3] <= take && vec_src_reg == 3'(flp_pkg::SRC_TMR1);
      end
   end

   //==============================================================
   // software registers
   //==============================================================
   // writes land only at the access edge with pready high, never in setup
   // control registers written over apb
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         source_enable_reg <= flp_pkg::SOURCE_ENABLE_RST;
         priority_high_reg <= flp_pkg::PRIORITY_RST[NS-1:0];
         priority_low_reg <= flp_pkg::PRIORITY_RST[NS-1:0];
         trigger_mode_reg <= flp_pkg::TRIGGER_MODE_RST;
         irq_mask_reg <= flp_pkg::IRQ_MASK_RST;
      end else if (wr_en) begin
         case (idx)
            // bit 6 is not implemented
            flp_pkg::IDX_SOURCE_ENABLE: source_enable_reg <= pwdata_i[7:0] & 8'hBF;
            flp_pkg::IDX_PRIORITY_HIGH: priority_high_reg <= pwdata_i[NS-1:0];
            flp_pkg::IDX_PRIORITY_LOW: priority_low_reg <= pwdata_i[NS-1:0];
            flp_pkg::IDX_TRIGGER_MODE: trigger_mode_reg <= pwdata_i[1:0];
            flp_pkg::IDX_IRQ_MASK: irq_mask_reg <= pwdata_i[flp_pkg::NUM_EV-1:0];
            default: ;
         endcase
      end
   end

   // only the bits that the read returned are cleared: the data is caught in
   // setup, so an event landing at the setup edge would otherwise be lost
   logic [flp_pkg::NUM_EV-1:0] status_clr;
   assign status_clr = (rd_done && idx == flp_pkg::IDX_IRQ_STATUS) ? prdata_reg[flp_pkg::NUM_EV-1:0] : '0;

   // sticky events; a read clears, but a new event the same edge wins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_status_reg <= '0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~status_clr)
            | {leave && !busy, leave && busy, take};
      end
   end

   // limitation: irq trails the status bits by one cycle
   // level interrupt from registered status so it follows the flops
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // read mux; unimplemented bits read as zero
   always_comb begin
      case (idx)
         flp_pkg::IDX_SOURCE_ENABLE: rd_val = {24'h0, source_enable_reg};
         flp_pkg::IDX_PRIORITY_HIGH: rd_val = {26'h0, priority_high_reg};
         flp_pkg::IDX_PRIORITY_LOW: rd_val = {26'h0, priority_low_reg};
         flp_pkg::IDX_TRIGGER_MODE: rd_val = {30'h0, trigger_mode_reg};
         flp_pkg::IDX_IRQ_STATUS: rd_val = {29'h0, irq_status_reg};
         flp_pkg::IDX_IRQ_MASK: rd_val = {29'h0, irq_mask_reg};
         flp_pkg::IDX_IN_SERVICE: rd_val = {28'h0, active};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // the slave never stretches a transfer: pready follows setup by one edge;
   // misaligned or unmapped addresses answer with pslverr and read zero
   // answer in the first access cycle; data caught in setup
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup_ph;
         pslverr_reg <= setup_ph && !addr_ok;
         if (setup_ph) begin
            prdata_reg <= (!pwrite_i && addr_ok) ? rd_val : 32'h0000_0000;
         end
      end
   end

   //==============================================================
   // outputs
   //==============================================================
   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign vec_valid_o = vec_valid_reg;
   assign vec_addr_o = vec_addr_reg;
   assign ext0_flag_clear_o = clear_reg[0];
   assign timer0_flag_clear_o = clear_reg[1];
   assign ext1_flag_clear_o = clear_reg[2];
   assign timer1_flag_clear_o = clear_reg[3];
   assign irq_o = irq_reg;
endmodule : flp_ctrl

/* tb/flp_ctrl_props.sv */
`timescale 1ns/1ps
//==============================================================
// port checks of the priority controller
//==============================================================
module flp_ctrl_props (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic ext0_flag_clear_o,
   input wire logic timer0_flag_clear_o,
   input wire logic ext1_flag_clear_o,
   input wire logic timer1_flag_clear_o,
   input wire logic vec_valid_o,
   input wire logic [7:0] vec_addr_o,
   input wire logic vec_ack_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // vector handed over at this edge
   wire logic take = vec_valid_o && vec_ack_i;
   // zero wait slave: answer in the first access cycle
   a_apb_ready_next: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
   a_ready_in_access: assert property (pready_o |-> psel_i && penable_i) else $error("ready outside access");
   a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   a_vector_legal: assert property (
      vec_valid_o |-> vec_addr_o inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B}) else $error("bad vector");
   // an offer is never withdrawn nor changed before it is taken
   a_offer_holds: assert property (vec_valid_o && !vec_ack_i |=> vec_valid_o && $stable(vec_addr_o))
      else $error("offer changed");
   a_offer_taken: assert property (take |=> !vec_valid_o) else $error("offer stays after ack");
   a_tmr0_clear: assert property (
      take && vec_addr_o == 8'h0B |=> timer0_flag_clear_o && !timer1_flag_clear_o) else $error("timer0 clear");
   a_tmr1_clear: assert property (
      take && vec_addr_o == 8'h1B |=> timer1_flag_clear_o && !timer0_flag_clear_o) else $error("timer1 clear");
   a_no_sw_clear: assert property (
      take && vec_addr_o >= 8'h23 |=> !(ext0_flag_clear_o || timer0_flag_clear_o || ext1_flag_clear_o
      || timer1_flag_clear_o)) else $error("serial or timer2 flag cleared");
   c_take_low: cover property (take && vec_addr_o == 8'h03);
   c_take_high: cover property (take && vec_addr_o == 8'h1B);
   c_slave_err: cover property (pslverr_o);
endmodule : flp_ctrl_props

bind flp_ctrl flp_ctrl_props u_props (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .ext0_flag_clear_o(ext0_flag_clear_o),
   .timer0_flag_clear_o(timer0_flag_clear_o), .ext1_flag_clear_o(ext1_flag_clear_o),
   .timer1_flag_clear_o(timer1_flag_clear_o), .vec_valid_o(vec_valid_o), .vec_addr_o(vec_addr_o),
   .vec_ack_i(vec_ack_i));

/* tb/flp_core_model.sv */
`timescale 1ns/1ps
//==============================================================
// core side: takes offered vectors after a set stall
//==============================================================
module flp_core_model (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic vec_valid_i,
   input wire logic [7:0] vec_addr_i,
   input wire logic [3:0] delay_i,
   output logic vec_ack_o,
   output logic taken_o,
   output logic [7:0] taken_addr_o
);
   logic [3:0] wait_reg; // cycles the offer has stood
   // ack is a one cycle pulse so a fresh offer is never taken twice
   always_ff @(posedge clk_i) begin
      taken_o <= vec_valid_i && vec_ack_o;
      taken_addr_o <= vec_addr_i;
      if (srst_i || !vec_valid_i || vec_ack_o) begin
         vec_ack_o <= 1'b0;
         wait_reg <= 4'h0;
      end else if (wait_reg >= delay_i) begin
         vec_ack_o <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule : flp_core_model

/* tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
   $display("ERROR %0t: got %0h expected %0h", $time, (a), (e)); end end
//==============================================================
// self checking bench of the priority controller
//==============================================================
module testbench;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reti = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, vec_valid, vec_ack, irq, taken;
   logic [7:0] fl = 8'h00, vec_addr, taken_addr; // ext0,tmr0,ext1,tmr1,rx,tx,t2ov,t2ext
   logic [3:0] clr, delay = 4'h0;
   logic [7:0] vq[$]; // expected vectors
   logic [32:0] rq[$]; // expected {error, read data}
   int n_errors = 0, compares = 0, cc[4] = '{0, 0, 0, 0};
   logic [7:0] r;
   always #2 clk = ~clk;
   flp_ctrl DUT (.clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .ext0_request_flag_i(fl[0]), .timer0_overflow_flag_i(fl[1]), .ext1_request_flag_i(fl[2]),
      .timer1_overflow_flag_i(fl[3]), .serial_rx_flag_i(fl[4]), .serial_tx_flag_i(fl[5]),
      .timer2_overflow_flag_i(fl[6]), .timer2_external_flag_i(fl[7]), .ext0_flag_clear_o(clr[0]),
      .timer0_flag_clear_o(clr[1]), .ext1_flag_clear_o(clr[2]), .timer1_flag_clear_o(clr[3]),
      .vec_valid_o(vec_valid), .vec_addr_o(vec_addr), .vec_ack_i(vec_ack), .reti_i(reti), .irq_o(irq));
   flp_core_model u_core (.clk_i(clk), .srst_i(srst), .vec_valid_i(vec_valid), .vec_addr_i(vec_addr),
      .delay_i(delay), .vec_ack_o(vec_ack), .taken_o(taken), .taken_addr_o(taken_addr));
   //==============================================================
   // monitor: results against the oldest note
   //==============================================================
   always @(posedge clk) begin
      if (taken) `CHK(taken_addr, vq.pop_front())
      if (psel && penable && pready === 1'b1 && !pwrite) `CHK({pslverr, prdata}, rq.pop_front())
      for (int k = 0; k < 4; k++) cc[k] += (clr[k] === 1'b1);
   end
   // apb transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // the wait ends when pready is sampled high; if it never comes, only the watchdog ends it
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] idx, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, idx, 32'h0);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // wait until at most n vectors are still due
   task automatic wq(input int n);
      for (int t = 0; t < 200 && vq.size() > n; t++) @(posedge clk);
      `CHK(vq.size(), n)
   endtask : wq
   task automatic ret;
      @(posedge clk) reti <= 1'b1;
      @(posedge clk) reti <= 1'b0;
   endtask : ret
   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      // the tests need well under two thousand cycles; allow ten thousand
      #40000;
      n_errors++;
      $display("ERROR %0t: timeout", $time);
      wrap_up();
   end
   initial begin
      void'($urandom(72580));
      cyc(10);
      srst <= 1'b0;
      rd(8'hA8, 33'h0);
      rd(8'hB7, 33'h0);
      rd(8'hB8, 33'h0);
      rd(8'hC0, 33'h0);
      rd(8'hC2, 33'h0);
      rd(8'hC3, 33'h0);
      rd(8'h10, {1'b1, 32'h0});
      r = 8'($urandom);
      apb(1'b1, 8'hA8, {24'h0, r});
      rd(8'hA8, {25'h0, r & 8'hBF});
      apb(1'b1, 8'hB7, 32'hFF);
      rd(8'hB7, 33'h3F);
      apb(1'b1, 8'hB8, 32'hFF);
      rd(8'hB8, 33'h3F);
      apb(1'b1, 8'hB7, 32'h0);
      apb(1'b1, 8'hB8, 32'h0);
      $display("test registers done");
      // all sources at level 0, edge mode: polling order decides
      apb(1'b1, 8'hA8, 32'hBF);
      apb(1'b1, 8'hC0, 32'h3);
      apb(1'b1, 8'hC2, 32'h1);
      vq = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B};
      @(posedge clk) fl <= 8'h9F;
      for (int i = 0; i < 6; i++) begin
         wq(5 - i);
         delay <= 4'($urandom % 5);
         fl <= fl & ~((i < 4) ? 8'(1 << i) : (i == 4) ? 8'h30 : 8'hC0);
         cyc(10);
         ret();
      end
      `CHK(irq, 1'b1)
      rd(8'hC1, 33'h3);
      cyc(3);
      `CHK(irq, 1'b0)
      $display("test polling done");
      // level mode: ext0 level 1, timer1 level 3, ext1 level 0
      apb(1'b1, 8'hC0, 32'h0);
      apb(1'b1, 8'hB8, 32'h09);
      apb(1'b1, 8'hB7, 32'h08);
      vq.push_back(8'h03);
      @(posedge clk) fl[0] <= 1'b1;
      wq(0);
      vq.push_back(8'h1B);
      @(posedge clk) fl[3] <= 1'b1;
      wq(0);
      @(posedge clk) fl[3] <= 1'b0;
      ret();
      rd(8'hC3, 33'h02);
      @(posedge clk) fl[2] <= 1'b1;
      cyc(12);
      vq.push_back(8'h13);
      @(posedge clk) fl[0] <= 1'b0;
      ret();
      wq(0);
      @(posedge clk) fl[2] <= 1'b0;
      ret();
      $display("test nesting done");
      // timer0 needs both its own and the global enable
      apb(1'b1, 8'hA8, 32'h80);
      @(posedge clk) fl[1] <= 1'b1;
      cyc(12);
      apb(1'b1, 8'hA8, 32'h3F);
      cyc(12);
      vq.push_back(8'h0B);
      apb(1'b1, 8'hA8, 32'h82);
      wq(0);
      @(posedge clk) fl[1] <= 1'b0;
      ret();
      `CHK(cc[0], 1)
      `CHK(cc[1], 2)
      `CHK(cc[2], 1)
      `CHK(cc[3], 2)
      // return with nothing in service
      rd(8'hC1, 33'h3);
      apb(1'b1, 8'hC2, 32'h4);
      ret();
      cyc(3);
      `CHK(irq, 1'b1)
      rd(8'hC1, 33'h4); cyc(3);
      `CHK(irq, 1'b0)
      $display("test enables and status done");
      wrap_up();
   end
endmodule : testbench
